// ===== logic/sdcc_channel_ctl.sv
// sdcc_channel_ctl: control register of one sigma-delta channel, APB slave, result readout
// assumes: the filter pulses result_valid/overflow_event on this clock; modulator is outside
`timescale 1ns/10ps
`default_nettype none
`include "sdcc_regs.svh"
module sdcc_channel_ctl
    import sdcc_pkg::*;
#(
    parameter bit HAS_BUFFER = 1'b1,
    parameter bit IS_LAST_CHANNEL = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    input wire sdcc_apb_req_t apb_req,
    output sdcc_apb_rsp_t apb_rsp,
    input wire logic result_valid,
    input wire logic [31:0] result_data,
    input wire logic overflow_event,
    output sdcc_cfg_t cfg,
    output sdcc_buf_speed_t buffer_speed,
    output logic buffer_high_speed,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [15:0] ctl;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [31:0] prdata;
        sdcc_cfg_t cfg;
        sdcc_buf_speed_t speed;
        logic high_speed;
        logic irq;
    } sdcc_state_t;

    sdcc_state_t s_q;
    sdcc_state_t s_d;
    logic [31:0] result_word;
    logic acc_wr;
    logic acc_rd;
    logic setup_rd;
    logic res_read;
    logic [11:0] addr;
    logic [1:0] evt;
    logic [15:0] wmask;

    function automatic logic [10:0] ratio_of(input logic xbit, input logic [1:0] code);
        logic [10:0] r;
        r = 11'h000;
        unique case ({xbit, code})
            3'b000: r = 11'h100;
            3'b001: r = 11'h080;
            3'b010: r = 11'h040;
            3'b011: r = 11'h020;
            3'b100: r = 11'h200;
            3'b101: r = 11'h400;
            default: r = 11'h000;
        endcase
        return r;
    endfunction

    // read value of one offset, zero where nothing is mapped
    function automatic logic [31:0] read_mux(input logic [11:0] a, input logic [15:0] ctl,
                                             input logic [1:0] stat, input logic [1:0] mask,
                                             input logic [31:0] res);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            `SDCC_CTL_OFF: v = {16'h0000, ctl};
            `SDCC_RES_OFF: v = ctl[`SDCC_HALF_BIT] ? {16'h0000, res[15:0]}
                                                    : {16'h0000, res[31:16]};
            `SDCC_STAT_OFF: v = {30'h0, stat};
            `SDCC_MASK_OFF: v = {30'h0, mask};
            `SDCC_INFO_OFF: v = {30'h0, IS_LAST_CHANNEL, HAS_BUFFER};
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    sdcc_result_store #(
        .WIDTH(32)
    ) u_store (
        .clock(clock),
        .rst(rst),
        .wr_en(result_valid),
        .wr_data(result_data),
        .rd_data(result_word)
    );

    ////////////////////////////////////////////////////////////////////////
    assign addr = apb_req.paddr;
    assign acc_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign acc_rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    // read data caught in setup so they stand through the access phase
    assign setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign res_read = acc_rd && (addr == `SDCC_RES_OFF);
    assign evt = {result_valid, overflow_event};
    // buffer field fixed when not built
    assign wmask = HAS_BUFFER ? `SDCC_CTL_WMASK
                              : (`SDCC_CTL_WMASK & ~(16'h0003 << `SDCC_BUF_LSB));

    always_comb begin
        s_d = s_q;
        if (acc_wr && addr == `SDCC_CTL_OFF) begin
            s_d.ctl = apb_req.pwdata[15:0] & wmask;
        end
        if (acc_wr && addr == `SDCC_STAT_OFF) begin
            s_d.stat = s_q.stat & ~apb_req.pwdata[1:0];
        end
        if (acc_wr && addr == `SDCC_MASK_OFF) begin
            s_d.mask = apb_req.pwdata[1:0];
        end
        // half select flips per result read while the toggle bit is set
        if (res_read && s_q.ctl[`SDCC_TOG_BIT]) begin
            s_d.ctl[`SDCC_HALF_BIT] = ~s_q.ctl[`SDCC_HALF_BIT];
        end
        if (res_read) begin
            s_d.ctl[`SDCC_RDY_BIT] = 1'b0;
        end
        // new result sets ready flag, set wins
        if (result_valid) begin
            s_d.ctl[`SDCC_RDY_BIT] = 1'b1;
        end
        if (overflow_event) begin
            s_d.ctl[`SDCC_OVF_BIT] = 1'b1;
        end
        s_d.stat = s_d.stat | evt;
        if (setup_rd) begin
            s_d.prdata = read_mux(addr, s_q.ctl, s_q.stat, s_q.mask, result_word);
        end
        s_d.speed = SDCC_BUF_OFF;
        s_d.high_speed = 1'b0;
        unique case (s_d.ctl[`SDCC_BUF_MSB:`SDCC_BUF_LSB])
            2'b01: s_d.speed = SDCC_BUF_SLOW;
            2'b10: s_d.speed = SDCC_BUF_MED;
            2'b11: s_d.high_speed = 1'b1;
            default: s_d.speed = SDCC_BUF_OFF;
        endcase
        s_d.cfg.input_buffer_mode = s_d.ctl[`SDCC_BUF_MSB:`SDCC_BUF_LSB];
        s_d.cfg.buffer_on = |s_d.ctl[`SDCC_BUF_MSB:`SDCC_BUF_LSB];
        s_d.cfg.unipolar_select = s_d.ctl[`SDCC_UNI_BIT];
        s_d.cfg.single_conversion_select = s_d.ctl[`SDCC_SNGL_BIT];
        s_d.cfg.decimation_ratio = ratio_of(s_d.ctl[`SDCC_XRATIO_BIT],
                                            s_d.ctl[`SDCC_RATIO_LSB+1:`SDCC_RATIO_LSB]);
        s_d.cfg.ratio_reserved = (s_d.cfg.decimation_ratio == 11'h000);
        s_d.cfg.result_format_select = s_d.ctl[`SDCC_FMT_BIT];
        s_d.cfg.conversion_start_bit = s_d.ctl[`SDCC_START_BIT];
        s_d.cfg.grouped_with_next = s_d.ctl[`SDCC_GRP_BIT] && !IS_LAST_CHANNEL;
        // result interrupt also follows the per-channel enable bit
        s_d.irq = |(s_d.stat & s_d.mask)
                  || (s_d.ctl[`SDCC_IE_BIT] && s_d.ctl[`SDCC_RDY_BIT]);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q.ctl <= `SDCC_CTL_RST;
            s_q.stat <= `SDCC_EVT_RST;
            s_q.mask <= `SDCC_EVT_RST;
            s_q.prdata <= 32'h0000_0000;
            s_q.cfg <= '{decimation_ratio: `SDCC_RATIO_RST, default: '0};
            s_q.speed <= SDCC_BUF_OFF;
            s_q.high_speed <= 1'b0;
            s_q.irq <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        apb_rsp.prdata = s_q.prdata;
        apb_rsp.pready = 1'b1;
        apb_rsp.pslverr = 1'b0;
        if (apb_req.psel && apb_req.penable) begin
            apb_rsp.pready = 1'b1;
        end
    end

    // outputs straight from the state register
    assign cfg = s_q.cfg;
    assign buffer_speed = s_q.speed;
    assign buffer_high_speed = s_q.high_speed;
    assign irq = s_q.irq;
endmodule
`default_nettype wire

// ===== logic/sdcc_regs.svh
// sdcc_regs.svh: offsets, field positions, reset values and codes of the channel control block
// assumes: included by its bare name from sdcc_channel_ctl and from the checker
`ifndef SDCC_REGS_SVH
`define SDCC_REGS_SVH
`define SDCC_CTL_OFF 12'h000
`define SDCC_RES_OFF 12'h004
`define SDCC_STAT_OFF 12'h008
`define SDCC_MASK_OFF 12'h00c
`define SDCC_INFO_OFF 12'h010
`define SDCC_CTL_RST 16'h0000
`define SDCC_CTL_WMASK 16'h7fff
`define SDCC_GRP_BIT 0
`define SDCC_START_BIT 1
`define SDCC_RDY_BIT 2
`define SDCC_IE_BIT 3
`define SDCC_FMT_BIT 4
`define SDCC_OVF_BIT 5
`define SDCC_HALF_BIT 6
`define SDCC_TOG_BIT 7
`define SDCC_RATIO_LSB 8
`define SDCC_SNGL_BIT 10
`define SDCC_XRATIO_BIT 11
`define SDCC_UNI_BIT 12
`define SDCC_BUF_LSB 13
`define SDCC_BUF_MSB 14
`define SDCC_EVT_RST 2'h0
`define SDCC_RATIO_RST 11'h100
`endif

// ===== logic/sdcc_pkg.sv
// sdcc_pkg: types of the channel control block
// assumes: sdcc_regs.svh supplies the numeric constants
package sdcc_pkg;
    typedef enum logic [2:0] {
        SDCC_BUF_OFF = 3'b001,
        SDCC_BUF_SLOW = 3'b010,
        SDCC_BUF_MED = 3'b100
    } sdcc_buf_speed_t;
    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } sdcc_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sdcc_apb_rsp_t;
    typedef struct packed {
        logic [1:0] input_buffer_mode;
        logic buffer_on;
        logic unipolar_select;
        logic single_conversion_select;
        logic [10:0] decimation_ratio;
        logic ratio_reserved;
        logic result_format_select;
        logic conversion_start_bit;
        logic grouped_with_next;
    } sdcc_cfg_t;
endpackage

// ===== logic/sdcc_result_store.sv
// sdcc_result_store: holds the latest 32-bit conversion result, read out of a register
// assumes: one clock, writer and reader in the same domain
`timescale 1ns/10ps
`default_nettype none
module sdcc_result_store #(
    parameter int WIDTH = 32
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] rd_data
);
    typedef struct packed {
        logic [WIDTH-1:0] word;
    } sdcc_store_state_t;
    sdcc_store_state_t state_q;
    sdcc_store_state_t state_d;
    always_comb begin
        state_d = state_q;
        if (wr_en) begin
            state_d.word = wr_data;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
    assign rd_data = state_q.word;
endmodule
`default_nettype wire

// ===== verif/sdcc_channel_ctl_assertions.sv
// checker of the channel control block, bound into every sdcc_channel_ctl
// assumes: sdcc_pkg compiled and sdcc_regs.svh on the include path
`timescale 1ns/10ps
`default_nettype none
`include "sdcc_regs.svh"
module sdcc_channel_ctl_assertions
    import sdcc_pkg::*;
#(
    parameter bit HAS_BUFFER = 1'b1,
    parameter bit IS_LAST_CHANNEL = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    input wire sdcc_apb_req_t apb_req,
    input wire sdcc_apb_rsp_t apb_rsp,
    input wire logic result_valid,
    input wire logic [31:0] result_data,
    input wire logic overflow_event,
    input wire sdcc_cfg_t cfg,
    input wire sdcc_buf_speed_t buffer_speed,
    input wire logic buffer_high_speed,
    input wire logic irq
);
default clocking @(posedge clock); endclocking
default disable iff (rst);
logic wr;
logic [3:0] wf;
logic g0;
logic [1:0] m;
assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == `SDCC_CTL_OFF;
assign wf = apb_req.pwdata[11:8];
assign g0 = apb_req.pwdata[0];
assign m = cfg.input_buffer_mode;
function automatic logic [10:0] rt(input logic [3:0] f);
    if (f[3]) begin
        return f[1] ? 11'h0 : (f[0] ? 11'h400 : 11'h200);
    end
    return 11'h100 >> f[1:0];
endfunction
AST_RATIO: assert property (wr |=> cfg.decimation_ratio == rt($past(wf)))
    else $error("ratio does not follow written code");
AST_RSV: assert property (cfg.ratio_reserved == (cfg.decimation_ratio == 11'h0))
    else $error("reserved ratio flag wrong");
AST_NOBUF: assert property (!HAS_BUFFER |-> m == 2'h0)
    else $error("buffer mode nonzero without buffer");
AST_BUF: assert property (buffer_high_speed == (m == 2'h3) && buffer_speed == (m == 2'h1
    ? SDCC_BUF_SLOW : m == 2'h2 ? SDCC_BUF_MED : SDCC_BUF_OFF))
    else $error("buffer speed decode wrong");
AST_RST: assert property ($past(rst) |-> cfg.decimation_ratio == 11'h100 && !irq && m == 2'h0)
    else $error("state after reset wrong");
AST_LAST: assert property (IS_LAST_CHANNEL |-> !cfg.grouped_with_next)
    else $error("last channel grouped");
AST_GRP: assert property (wr |=> cfg.grouped_with_next == ($past(g0) && !IS_LAST_CHANNEL))
    else $error("grouping does not follow write");
AST_BUS: assert property (apb_req.psel |-> apb_rsp.pready && !apb_rsp.pslverr)
    else $error("bus answer wrong");
endmodule
bind sdcc_channel_ctl sdcc_channel_ctl_assertions #(.HAS_BUFFER(HAS_BUFFER),
    .IS_LAST_CHANNEL(IS_LAST_CHANNEL)) u_chk (.clock(clock), .rst(rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .result_valid(result_valid), .result_data(result_data),
    .overflow_event(overflow_event), .cfg(cfg), .buffer_speed(buffer_speed),
    .buffer_high_speed(buffer_high_speed), .irq(irq));
`default_nettype wire

// ===== verif/sigma_delta_channel_control_tb_top.sv
// testbench of the channel control block: APB master tasks and register sequences
// assumes: design and checker compiled before it
`timescale 1ns/10ps
`default_nettype none
module sigma_delta_channel_control_tb_top
    import sdcc_pkg::*;
;
logic clock = 1'b0;
logic rst = 1'b1;
logic rv = 1'b0;
logic ov = 1'b0;
logic [31:0] rdat = 32'h0;
sdcc_apb_req_t req = '0;
sdcc_apb_rsp_t rsp;
sdcc_cfg_t cfg;
sdcc_buf_speed_t spd;
logic hs;
logic irq;
int fail_count = 0;
int check_count = 0;
logic [31:0] rdata = 32'h0;
logic [31:0] tbl[8] = '{32'h100, 32'h80, 32'h40, 32'h20, 32'h200, 32'h400, 32'h0, 32'h0};
logic [31:0] bexp[4] = '{32'h1, 32'h2, 32'h4, 32'h9};
always #2 clock = ~clock;
sdcc_channel_ctl uut (.clock(clock), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .result_valid(rv), .result_data(rdat), .overflow_event(ov), .cfg(cfg),
    .buffer_speed(spd), .buffer_high_speed(hs), .irq(irq));
task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
        $display("SIMULATION PASSED");
    end else begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask
task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
        fail_count++;
        $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
endtask
// one transfer; read data taken at the edge that sees pready high
task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin
        @(posedge clock);
        n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (rsp.pready !== 1'b1) begin
        fail_count++;
        print_verdict();
    end
    rdata = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clock);
endtask
task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdata, e);
endtask
task automatic pulse(input logic r, input logic [31:0] d);
    rv <= r;
    ov <= !r;
    rdat <= d;
    @(posedge clock);
    rv <= 1'b0;
    ov <= 1'b0;
    @(posedge clock);
endtask
initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd(12'h000, 32'h0);
    bus(1'b1, 12'h000, 32'hffff);
    rd(12'h000, 32'h7fff);
    chk({12'h0, cfg}, 32'hf800f);
    for (int i = 0; i < 8; i++) begin
        bus(1'b1, 12'h000, {20'h0, i[2], 1'b0, i[1:0], 8'h0});
        chk({21'h0, cfg.decimation_ratio}, tbl[i]);
    end
    for (int j = 0; j < 4; j++) begin
        bus(1'b1, 12'h000, {17'h0, j[1:0], 13'h0});
        chk({28'h0, hs, spd}, bexp[j]);
    end
    bus(1'b1, 12'h000, 32'h1);
    chk({31'h0, cfg.grouped_with_next}, 32'h1);
    bus(1'b1, 12'h000, 32'h8);
    pulse(1'b1, 32'h12345678);
    chk({31'h0, irq}, 32'h1);
    rd(12'h000, 32'hc);
    rd(12'h004, 32'h1234);
    rd(12'h000, 32'h8);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 12'h008, 32'h3);
    bus(1'b1, 12'h000, 32'hc0);
    pulse(1'b1, 32'haaaa5555);
    rd(12'h004, 32'h5555);
    rd(12'h004, 32'haaaa);
    rd(12'h000, 32'hc0);
    bus(1'b1, 12'h000, 32'h0);
    bus(1'b1, 12'h00c, 32'h1);
    pulse(1'b0, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd(12'h000, 32'h20);
    rd(12'h008, 32'h3);
    rd(12'h00c, 32'h1);
    rd(12'h010, 32'h1);
    bus(1'b1, 12'h00c, 32'h0);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 12'h00c, 32'h1);
    bus(1'b1, 12'h008, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(12'h020, 32'h0);
    print_verdict();
end
endmodule
`default_nettype wire
